// File: rtl/op_mode_clock_manager.sv
// Operating-mode and oscillator manager: normal, slow, green, power-down.
// Assumes oscillator tick inputs are one-cycle pulses on ref_clk_in;
// wake port pins are asynchronous and synchronised here.
// Functional notes
// - Slow mode instruction clock is slow RC/4.
// - Slow RC feeds watchdog and slow system clock.
// - Slow RC stops: power-down, or green+32K+no watchdog.
// - No control bit stops slow RC alone.
// - Reset releases into normal mode, fast clock.
// - Normal mode runs fast and slow oscillators.
// - Select bit 0 fast clock, 1 slow RC.
// - Slow mode keeps fast oscillator until stop bit.
// - Sleep request stops execution and all oscillators.
// - Power-down wake clears sleep request bit.
// - Power-down wakes on pins or reset, to normal.
// - Port b wake gated per pin, a always.
// - Fast stop in normal acts as power-down.
// - Cpu mode 10 enters green; wake clears it.
// - Green keeps system clock unless its source stops (fast stop, or slow RC under 32K+no watchdog); halts execution.
// - Green runs only wake timer, if enabled.
// - Green wakes on pins or timer overflow.
// - Green wake returns to the previous mode.
// - Timer wake off: green leaves on pins only.
// - Cpu mode: 00 run, 01 sleep, 10 green, 11 reserved.
// - Power-down wake waits 2048 fast clocks.
`timescale 1ns/100ps
`default_nettype none
`include "op_mode_defines.svh"

module op_mode_clock_manager (
    input  wire logic                              ref_clk_in,
    input  wire logic                              nrst_in,
    input  wire logic                              ce_in,
    input  wire logic                              oscillator_mode_register_wr_in,
    input  wire op_mode_pkg::oscillator_mode_register_t oscillator_mode_register_wdata_in,
    input  wire op_mode_pkg::osc_option_t          osc_option_in,
    input  wire logic                              watchdog_on_in,
    input  wire logic [3:0]                        fcpu_div_in,
    input  wire logic                              fast_osc_tick_in,
    input  wire logic                              slow_rc_tick_in,
    input  wire logic [`PORT_A_W-1:0]              wake_port_a_in,
    input  wire logic [`PORT_B_W-1:0]              wake_port_b_in,
    input  wire logic [`PORT_B_W-1:0]              port_b_wake_enable_in,
    input  wire logic                              wake_timer_on_in,
    input  wire logic                              auxiliary_timer_on_in,
    input  wire logic                              wake_timer_ovf_in,
    output op_mode_pkg::oscillator_mode_register_t oscillator_mode_register_out,
    output op_mode_pkg::mode_t                     mode_out,
    output op_mode_pkg::osc_en_t                   osc_en_out,
    output logic                                   sys_tick_out,
    output logic                                   cpu_tick_out,
    output logic                                   cpu_run_out,
    output logic                                   watchdog_tick_out,
    output logic                                   wake_timer_run_out,
    output logic                                   auxiliary_timer_run_out,
    output logic                                   wake_out
);
    import op_mode_pkg::*;
    default clocking main_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_run(input mode_t m);
        is_run = (m == MODE_NORMAL) || (m == MODE_SLOW);
    endfunction : is_run

    function automatic logic is_halt(input mode_t m);
        is_halt = (m == MODE_SLEEP) || (m == MODE_NOCLK);
    endfunction : is_halt

    ////////////////////////////////////////////////////////////////////
    // Wake pin synchronisers

    logic [`PORT_A_W-1:0] pa_meta;
    logic [`PORT_A_W-1:0] pa_sync;
    logic [`PORT_A_W-1:0] pa_snap;
    logic [`PORT_B_W-1:0] pb_meta;
    logic [`PORT_B_W-1:0] pb_sync;
    logic [`PORT_B_W-1:0] pb_snap;
    logic                 pin_change;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pa_meta <= '0;
            pa_sync <= '0;
            pb_meta <= '0;
            pb_sync <= '0;
        end else if (ce_in) begin
            pa_meta <= wake_port_a_in;
            pa_sync <= pa_meta;
            pb_meta <= wake_port_b_in;
            pb_sync <= pb_meta;
        end
    end

    // Port a always armed, port b per enable bit
    assign pin_change = (|(pa_sync ^ pa_snap))
        || (|((pb_sync ^ pb_snap) & port_b_wake_enable_in));

    ////////////////////////////////////////////////////////////////////
    // Mode sequencer

    mode_t                     state;
    mode_t                     next_state;
    oscillator_mode_register_t oscillator_mode_register;
    logic                      clk_sel_slow;
    logic [11:0]               warm_cnt;
    logic                      timer_wake;
    logic                      wake_evt;

    assign timer_wake = wake_timer_on_in && wake_timer_ovf_in;
    assign wake_evt   = (state == MODE_GREEN)
        ? (pin_change || timer_wake)
        : (is_halt(state) && pin_change);

    always_comb begin
        next_state = state;
        unique case (state)
            MODE_NORMAL: begin
                if (oscillator_mode_register.cpu_mode_field == `CPU_MODE_SLEEP)
                    next_state = MODE_SLEEP;
                else if (oscillator_mode_register.cpu_mode_field == `CPU_MODE_GREEN)
                    next_state = MODE_GREEN;
                else if (oscillator_mode_register.fast_osc_stop)
                    next_state = MODE_NOCLK;
                else if (oscillator_mode_register.slow_clock_select && slow_rc_tick_in)
                    next_state = MODE_SLOW;
            end
            MODE_SLOW: begin
                if (oscillator_mode_register.cpu_mode_field == `CPU_MODE_SLEEP)
                    next_state = MODE_SLEEP;
                else if (oscillator_mode_register.cpu_mode_field == `CPU_MODE_GREEN)
                    next_state = MODE_GREEN;
                else if (!oscillator_mode_register.slow_clock_select && fast_osc_tick_in)
                    next_state = MODE_NORMAL;
            end
            MODE_GREEN: begin
                if (wake_evt)
                    next_state = clk_sel_slow ? MODE_SLOW
                                              : MODE_NORMAL;
            end
            MODE_SLEEP, MODE_NOCLK: begin
                if (wake_evt)
                    next_state = MODE_WARM;
            end
            MODE_WARM: begin
                if (fast_osc_tick_in && warm_cnt == `WARMUP_LAST)
                    next_state = MODE_NORMAL;
            end
            default: next_state = MODE_NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= MODE_NORMAL;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Clock source follows state at a tick of the new source, or switches to fast on entering warm-up
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clk_sel_slow <= 1'b0;
        end else if (ce_in) begin
            if (next_state == MODE_SLOW)
                clk_sel_slow <= 1'b1;
            else if (next_state == MODE_NORMAL
                     || next_state == MODE_WARM)
                clk_sel_slow <= 1'b0;
        end
    end

    // Wake-up wait counts fast oscillator clocks only
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            warm_cnt <= '0;
        end else if (ce_in) begin
            if (state != MODE_WARM)
                warm_cnt <= '0;
            else if (fast_osc_tick_in)
                warm_cnt <= warm_cnt + 12'h001;
        end
    end

    // Pin levels captured as the cpu stops
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pa_snap <= '0;
            pb_snap <= '0;
        end else if (ce_in) begin
            if (is_run(state) && !is_run(next_state)) begin
                pa_snap <= pa_sync;
                pb_snap <= pb_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator mode register

    // Writes only land while code runs, so they never meet a wake clear
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oscillator_mode_register <= '0;
        end else if (ce_in) begin
            if (oscillator_mode_register_wr_in && is_run(state)) begin
                oscillator_mode_register.slow_clock_select <= oscillator_mode_register_wdata_in.slow_clock_select;
                oscillator_mode_register.fast_osc_stop     <= oscillator_mode_register_wdata_in.fast_osc_stop;
                if (oscillator_mode_register_wdata_in.cpu_mode_field != `CPU_MODE_RSVD)
                    oscillator_mode_register.cpu_mode_field <=
                        oscillator_mode_register_wdata_in.cpu_mode_field;
            end else if (wake_evt) begin
                oscillator_mode_register.cpu_mode_field <= `CPU_MODE_RUN;
                if (state == MODE_NOCLK)
                    oscillator_mode_register.fast_osc_stop <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator enables

    logic    fast_on;
    logic    slow_on;
    logic    int_fast;
    osc_en_t next_osc_en;

    assign int_fast = (osc_option_in == OPT_INT_FAST)
                   || (osc_option_in == OPT_INT_FAST_RTC);

    always_comb begin
        unique case (next_state)
            MODE_NORMAL, MODE_WARM: fast_on = 1'b1;
            MODE_SLOW, MODE_GREEN:  fast_on = !oscillator_mode_register.fast_osc_stop;
            default:                fast_on = 1'b0;
        endcase
        // Only mode, option and watchdog enable decide; there is no direct stop bit
        slow_on = !is_halt(next_state)
            && !(next_state == MODE_GREEN
                 && osc_option_in == OPT_EXT_32K
                 && !watchdog_on_in);
        next_osc_en.external_fast_osc = fast_on && !int_fast;
        next_osc_en.internal_fast_rc  = fast_on && int_fast;
        next_osc_en.internal_slow_rc  = slow_on;
    end

    ////////////////////////////////////////////////////////////////////
    // System and instruction clock ticks

    logic       sys_tick;
    logic [3:0] div_cnt;
    logic [3:0] div_last;

    // Selected source only; no tick during the changeover cycle
    assign sys_tick = (state == next_state) && !is_halt(state)
        && (clk_sel_slow ? (slow_rc_tick_in && osc_en_out.internal_slow_rc)
                         : (fast_osc_tick_in && state != MODE_WARM));
    assign div_last = clk_sel_slow ? `SLOW_DIV_LAST
                                   : fcpu_div_in;

    // Divider restarts on any mode change so no short cycle occurs
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt      <= '0;
            cpu_tick_out <= 1'b0;
        end else if (ce_in) begin
            cpu_tick_out <= 1'b0;
            if (state != next_state || !is_run(state)) begin
                div_cnt <= '0;
            end else if (sys_tick) begin
                if (div_cnt >= div_last) begin
                    div_cnt      <= '0;
                    cpu_tick_out <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            osc_en_out              <= '1;
            sys_tick_out            <= 1'b0;
            cpu_run_out             <= 1'b1;
            watchdog_tick_out       <= 1'b0;
            wake_timer_run_out      <= 1'b0;
            auxiliary_timer_run_out <= 1'b0;
            wake_out                <= 1'b0;
            mode_out                <= MODE_NORMAL;
            oscillator_mode_register_out                <= '0;
        end else if (ce_in) begin
            osc_en_out        <= next_osc_en;
            sys_tick_out      <= sys_tick;
            cpu_run_out       <= is_run(next_state);
            watchdog_tick_out <= slow_rc_tick_in
                && osc_en_out.internal_slow_rc;
            wake_timer_run_out <= wake_timer_on_in
                && (is_run(next_state) || next_state == MODE_GREEN);
            auxiliary_timer_run_out <= auxiliary_timer_on_in
                && is_run(next_state);
            wake_out <= wake_evt;
            mode_out <= next_state;
            oscillator_mode_register_out <= oscillator_mode_register;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence green_left_s;
        mode_out == MODE_GREEN ##1 mode_out != MODE_GREEN;
    endsequence
    sequence warm_left_s;
        mode_out == MODE_WARM ##1 mode_out == MODE_NORMAL;
    endsequence
    sleep_osc_off_a: assert property (
        mode_out == MODE_SLEEP |-> osc_en_out == '0 && !cpu_run_out)
        else $error("Oscillator running in power-down");
    normal_osc_on_a: assert property (
        mode_out == MODE_NORMAL |-> osc_en_out.internal_slow_rc
            && (osc_en_out.external_fast_osc || osc_en_out.internal_fast_rc))
        else $error("Normal mode without both oscillators");
    slow_rc_stop_a: assert property (
        !osc_en_out.internal_slow_rc |-> mode_out inside
            {MODE_SLEEP, MODE_NOCLK}
            || (mode_out == MODE_GREEN && osc_option_in == OPT_EXT_32K
                && !watchdog_on_in))
        else $error("Slow RC stopped outside allowed modes");
    sleep_clear_a: assert property (
        ce_in && state == MODE_SLEEP && wake_evt
            |=> oscillator_mode_register.cpu_mode_field == `CPU_MODE_RUN ##1
                mode_out == MODE_WARM)
        else $error("Sleep request not cleared on wake");
    // Exit edge is the one that took the last tick, one sample back
    warm_time_a: assert property (
        warm_left_s |-> $past(warm_cnt) == `WARMUP_LAST)
        else $error("Wake-up wait not 2048 fast clocks");
    green_return_a: assert property (
        green_left_s |-> mode_out == ($past(clk_sel_slow)
            ? MODE_SLOW : MODE_NORMAL))
        else $error("Green wake to wrong mode");
    // Timer run output is registered, so it trails its enable
    green_halt_a: assert property (
        mode_out == MODE_GREEN |-> !cpu_run_out && !auxiliary_timer_run_out
            && wake_timer_run_out == $past(wake_timer_on_in))
        else $error("Function active in green mode");
    halt_hold_a: assert property (
        ce_in && is_halt(state) && !pin_change |=> is_halt(state))
        else $error("Power-down left without pin change");
    slow_div_a: assert property (
        ce_in && state == MODE_SLOW && next_state == MODE_SLOW
            && sys_tick && div_cnt == `SLOW_DIV_LAST
            |=> cpu_tick_out)
        else $error("Slow instruction tick not every fourth");

endmodule : op_mode_clock_manager
`default_nettype wire

// File: shared/op_mode_defines.svh
// Constants for the operating-mode and oscillator manager.
// Assumes one 100 MHz reference clock; oscillators arrive as tick pulses.
`ifndef OP_MODE_DEFINES_SVH
`define OP_MODE_DEFINES_SVH

// Reference clock period in ns
`define REF_CLK_PERIOD_NS 10
// Cpu mode field codes
`define CPU_MODE_RUN      2'h0
`define CPU_MODE_SLEEP    2'h1
`define CPU_MODE_GREEN    2'h2
`define CPU_MODE_RSVD     2'h3
// Slow mode instruction divider, minus one
`define SLOW_DIV_LAST     4'h3
// Fast oscillator clocks waited after power-down wake-up
`define WARMUP_CLKS       12'h800
`define WARMUP_LAST       12'h7FF
// Wake port widths
`define PORT_A_W          8
`define PORT_B_W          4

`endif

// File: shared/op_mode_pkg.sv
// Types shared by the operating-mode manager and its bench.
// Assumes op_mode_defines.svh supplies the numeric constants.
package op_mode_pkg;

    // Gray along normal-slow-green-sleep-warm-noclk
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SLOW   = 3'h1,
        MODE_GREEN  = 3'h3,
        MODE_SLEEP  = 3'h2,
        MODE_WARM   = 3'h6,
        MODE_NOCLK  = 3'h4
    } mode_t;

    typedef enum logic [2:0] {
        OPT_INT_FAST     = 3'h0,
        OPT_INT_FAST_RTC = 3'h1,
        OPT_EXT_RC       = 3'h2,
        OPT_EXT_32K      = 3'h3,
        OPT_EXT_12M      = 3'h4,
        OPT_EXT_4M       = 3'h5
    } osc_option_t;

    // Oscillator mode register image
    typedef struct packed {
        logic [1:0] cpu_mode_field;
        logic       slow_clock_select;
        logic       fast_osc_stop;
    } oscillator_mode_register_t;

    typedef struct packed {
        logic external_fast_osc;
        logic internal_fast_rc;
        logic internal_slow_rc;
    } osc_en_t;

endpackage : op_mode_pkg

// File: tb/tb_top.sv
// Self-checking bench for the operating-mode and oscillator manager.
// Assumes the package and design compile first; the bench drives all ports.
`timescale 1ns/100ps
`default_nettype none
`include "op_mode_defines.svh"

module tb_top;
    import op_mode_pkg::*;

    logic                      ref_clk_in = 1'b0;
    logic                      nrst_in = 1'b0;
    logic                      ce_in = 1'b1;
    logic                      oscillator_mode_register_wr_in = 1'b0;
    oscillator_mode_register_t oscillator_mode_register_wdata_in = 4'h0;
    osc_option_t               osc_option_in = OPT_INT_FAST;
    logic                      watchdog_on_in = 1'b1;
    logic [3:0]                fcpu_div_in = 4'h1;
    logic                      fast_osc_tick_in = 1'b0;
    logic                      slow_rc_tick_in = 1'b0;
    logic [`PORT_A_W-1:0]      wake_port_a_in = 8'h00;
    logic [`PORT_B_W-1:0]      wake_port_b_in = 4'h0;
    logic [`PORT_B_W-1:0]      port_b_wake_enable_in = 4'h0;
    logic                      wake_timer_on_in = 1'b1;
    logic                      auxiliary_timer_on_in = 1'b1;
    logic                      wake_timer_ovf_in = 1'b0;
    oscillator_mode_register_t oscillator_mode_register_out;
    mode_t                     mode_out;
    osc_en_t                   osc_en_out;
    logic                      sys_tick_out;
    logic                      cpu_tick_out;
    logic                      cpu_run_out;
    logic                      watchdog_tick_out;
    logic                      wake_timer_run_out;
    logic                      auxiliary_timer_run_out;
    logic                      wake_out;
    logic [2:0]                tick_cnt = 3'h0;
    int                        err_count = 0;
    int                        checks_done = 0;
    int                        nw;
    int                        nd;
    int                        gap;
    int                        n;
    int                        k;
    logic                      found;

    op_mode_clock_manager op_mode_clock_manager_i (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .oscillator_mode_register_wr_in(oscillator_mode_register_wr_in), .oscillator_mode_register_wdata_in(oscillator_mode_register_wdata_in),
        .osc_option_in(osc_option_in), .watchdog_on_in(watchdog_on_in),
        .fcpu_div_in(fcpu_div_in), .fast_osc_tick_in(fast_osc_tick_in),
        .slow_rc_tick_in(slow_rc_tick_in), .wake_port_a_in(wake_port_a_in),
        .wake_port_b_in(wake_port_b_in),
        .port_b_wake_enable_in(port_b_wake_enable_in),
        .wake_timer_on_in(wake_timer_on_in),
        .auxiliary_timer_on_in(auxiliary_timer_on_in),
        .wake_timer_ovf_in(wake_timer_ovf_in), .oscillator_mode_register_out(oscillator_mode_register_out),
        .mode_out(mode_out), .osc_en_out(osc_en_out),
        .sys_tick_out(sys_tick_out), .cpu_tick_out(cpu_tick_out),
        .cpu_run_out(cpu_run_out), .watchdog_tick_out(watchdog_tick_out),
        .wake_timer_run_out(wake_timer_run_out),
        .auxiliary_timer_run_out(auxiliary_timer_run_out),
        .wake_out(wake_out)
    );

    always #(`REF_CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;

    // Oscillators tick only while enabled: fast every 2, slow every 8 cycles
    always @(posedge ref_clk_in) begin
        tick_cnt <= tick_cnt + 3'h1;
        fast_osc_tick_in <= nrst_in & tick_cnt[0]
            & (osc_en_out.external_fast_osc | osc_en_out.internal_fast_rc);
        slow_rc_tick_in <= nrst_in & (tick_cnt == 3'h7)
            & osc_en_out.internal_slow_rc;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks done %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
            err_count++;
        end
    endtask : check

    task automatic write_oscillator_mode_register(input logic [1:0] cm, input logic sel,
                              input logic stp);
        @(posedge ref_clk_in);
        oscillator_mode_register_wr_in <= 1'b1;
        oscillator_mode_register_wdata_in <= {cm, sel, stp};
        @(posedge ref_clk_in);
        oscillator_mode_register_wr_in <= 1'b0;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : write_oscillator_mode_register

    task automatic wait_mode(input mode_t m, input int lim);
        int i;
        i = 0;
        while (mode_out !== m && i < lim) begin
            @(negedge ref_clk_in);
            i++;
        end
        if (mode_out !== m) begin
            $display("FAIL mode_wait expected %0h seen %0h", m, mode_out);
            err_count++;
            give_verdict();
        end
    endtask : wait_mode

    task automatic wait_wake(input int lim, output logic hit);
        hit = 1'b0;
        repeat (lim) begin
            @(negedge ref_clk_in);
            if (!hit && wake_out === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
    endtask : wait_wake

    task automatic count_pulses(input int cyc, output int w, output int d);
        w = 0;
        d = 0;
        repeat (cyc) begin
            @(negedge ref_clk_in);
            if (wake_out === 1'b1) w++;
            if (watchdog_tick_out === 1'b1) d++;
        end
    endtask : count_pulses

    // Gap between the 2nd and 3rd tick, clear of any mode-change edge
    task automatic tick_gap(output int g);
        int i;
        int seen;
        int last;
        seen = 0;
        last = 0;
        g = 0;
        for (i = 0; i < 400 && seen < 3; i++) begin
            @(negedge ref_clk_in);
            if (cpu_tick_out === 1'b1) begin
                seen++;
                g = i - last;
                last = i;
            end
        end
    endtask : tick_gap

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(negedge ref_clk_in);
        check("mode", mode_out, MODE_NORMAL);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h0);
        check("osc_en", osc_en_out, 3'h7);
        check("cpu_run", cpu_run_out, 1'b1);
        tick_gap(gap);
        check("normal_gap", gap, 32'h4);
        count_pulses(32, nw, nd);
        check("wdt_ticks", nd, 32'h4);
        write_oscillator_mode_register(2'h0, 1'b1, 1'b0);
        wait_mode(MODE_SLOW, 40);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h2);
        check("osc_en", osc_en_out, 3'h3);
        check("aux_run", auxiliary_timer_run_out, 1'b1);
        tick_gap(gap);
        check("slow_gap", gap, 32'h20);
        write_oscillator_mode_register(2'h3, 1'b1, 1'b1);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h3);
        check("osc_en", osc_en_out, 3'h1);
        write_oscillator_mode_register(2'h2, 1'b1, 1'b1);
        check("mode", mode_out, MODE_GREEN);
        check("cpu_run", cpu_run_out, 1'b0);
        check("osc_en", osc_en_out, 3'h1);
        check("aux_run", auxiliary_timer_run_out, 1'b0);
        check("wt_run", wake_timer_run_out, 1'b1);
        @(posedge ref_clk_in);
        wake_timer_on_in <= 1'b0;
        wake_timer_ovf_in <= 1'b1;
        @(posedge ref_clk_in);
        wake_timer_ovf_in <= 1'b0;
        count_pulses(12, nw, nd);
        check("wake_off", nw, 32'h0);
        check("mode", mode_out, MODE_GREEN);
        @(posedge ref_clk_in);
        wake_timer_on_in <= 1'b1;
        wake_timer_ovf_in <= 1'b1;
        @(posedge ref_clk_in);
        wake_timer_ovf_in <= 1'b0;
        wait_wake(8, found);
        check("wake", found, 1'b1);
        check("mode", mode_out, MODE_SLOW);
        // Register image trails the mode change by one cycle
        @(negedge ref_clk_in);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h3);
        write_oscillator_mode_register(2'h0, 1'b1, 1'b0);
        // Fast oscillator settles for 320 slow RC periods first
        repeat (2560) @(posedge ref_clk_in);
        write_oscillator_mode_register(2'h0, 1'b0, 1'b0);
        wait_mode(MODE_NORMAL, 40);
        // Green on a 32K fast clock with the watchdog off
        @(posedge ref_clk_in);
        osc_option_in <= OPT_EXT_32K;
        watchdog_on_in <= 1'b0;
        write_oscillator_mode_register(2'h2, 1'b0, 1'b0);
        check("mode", mode_out, MODE_GREEN);
        check("slow_rc", osc_en_out.internal_slow_rc, 1'b0);
        check("ext_fast", osc_en_out.external_fast_osc, 1'b1);
        // Cpu halted, yet the fast source still ticks every 2 cycles
        n = 0;
        repeat (16) begin
            @(negedge ref_clk_in);
            if (sys_tick_out === 1'b1) n++;
        end
        check("sys_ticks", n, 32'h8);
        @(posedge ref_clk_in);
        wake_port_a_in[0] <= 1'b1;
        wait_wake(8, found);
        check("wake", found, 1'b1);
        check("mode", mode_out, MODE_NORMAL);
        check("slow_rc", osc_en_out.internal_slow_rc, 1'b1);
        @(posedge ref_clk_in);
        osc_option_in <= OPT_INT_FAST;
        watchdog_on_in <= 1'b1;
        write_oscillator_mode_register(2'h1, 1'b0, 1'b0);
        check("mode", mode_out, MODE_SLEEP);
        check("osc_en", osc_en_out, 3'h0);
        check("cpu_run", cpu_run_out, 1'b0);
        @(posedge ref_clk_in);
        wake_port_b_in[1] <= 1'b1;
        count_pulses(16, nw, nd);
        check("wake_gated", nw, 32'h0);
        check("wdt_ticks", nd, 32'h0);
        write_oscillator_mode_register(2'h0, 1'b1, 1'b0);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h4);
        @(posedge ref_clk_in);
        port_b_wake_enable_in <= 4'h2;
        wait_wake(8, found);
        check("wake", found, 1'b1);
        check("mode", mode_out, MODE_WARM);
        n = 0;
        for (k = 0; k < 5000 && mode_out === MODE_WARM; k++) begin
            if (fast_osc_tick_in === 1'b1) n++;
            @(negedge ref_clk_in);
        end
        check("warm_ticks", n, 32'h800);
        check("mode", mode_out, MODE_NORMAL);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h0);
        check("cpu_run", cpu_run_out, 1'b1);
        write_oscillator_mode_register(2'h0, 1'b0, 1'b1);
        check("mode", mode_out, MODE_NOCLK);
        @(posedge ref_clk_in);
        wake_port_a_in[7] <= 1'b1;
        wait_wake(8, found);
        check("wake", found, 1'b1);
        check("mode", mode_out, MODE_WARM);
        wait_mode(MODE_NORMAL, 5000);
        check("oscillator_mode_register", oscillator_mode_register_out, 4'h0);
        give_verdict();
    end

endmodule : tb_top
`default_nettype wire
